// file: logic/sac_pkg.sv
// Constants, state type and timing for the serial converter readout block
// Functional notes
// - Start falling edge holds sample, starts conversion
// - Busy rises on start edge, falls at end
// - Start still low at end: power down
// - Rising start edge while powered down wakes
// - Next result bit on each shift falling edge
// - Frame is two zeros then 14 bits
// - After edge sixteen hold, then release output
// - Bipolar twos complement, unipolar straight binary
// - Conversion 5 us; auto-sleep 10 us total
package sac_pkg;
   localparam int CLK_FREQ_MHZ       = 50;
   localparam int CONV_TIME_NS       = 5000;
   localparam int AUTO_SLEEP_TIME_NS = 10000;
   localparam int WAKE_TIME_NS       = AUTO_SLEEP_TIME_NS - CONV_TIME_NS;
   localparam int CONV_CYCLES_I      = (CONV_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam int WAKE_CYCLES_I      = (WAKE_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;

   localparam int CNT_W    = 9;
   localparam int DATA_W   = 14;
   localparam int FRAME_W  = 16;
   localparam int BITCNT_W = 5;

   localparam logic [CNT_W-1:0]    CONV_CYCLES  = CNT_W'(CONV_CYCLES_I);
   localparam logic [CNT_W-1:0]    WAKE_CYCLES  = CNT_W'(WAKE_CYCLES_I);
   localparam logic [CNT_W-1:0]    CNT_RST      = 9'h000;
   localparam logic [DATA_W-1:0]   SIGN_FLIP    = 14'h2000;
   localparam logic [DATA_W-1:0]   CODE_RST     = 14'h0000;
   localparam logic [1:0]          LEAD_ZEROS   = 2'h0;
   localparam logic [FRAME_W-1:0]  WORD_RST     = 16'h0000;
   localparam logic [BITCNT_W-1:0] BITCNT_IDLE  = 5'h00;
   localparam logic [BITCNT_W-1:0] BITCNT_FIRST = 5'h01;
   localparam logic [BITCNT_W-1:0] BITCNT_PRE   = 5'h0f;
   localparam logic [BITCNT_W-1:0] BITCNT_LAST  = 5'h10;

   typedef enum logic [1:0] {
      ST_IDLE      = 2'b00,
      ST_CONVERT   = 2'b01,
      ST_POWERDOWN = 2'b10,
      ST_WAKE      = 2'b11
   } sac_state_t;
endpackage

// file: logic/sac_sync2.sv
// Two flip-flop synchroniser for levels entering the system clock
`timescale 1ns/1ns
module sac_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic [WIDTH-1:0] din,
   output logic      [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge clk) begin
      meta_reg <= din;
      dout     <= meta_reg;
   end
endmodule

// file: logic/sac_readout.sv
// Conversion control, power sequencing and serial result port
`timescale 1ns/1ns
module sac_readout (
   input  wire logic        clk_sys,
   input  wire logic        srst,
   input  wire logic        conversionStartN,
   input  wire logic        unipolarMode,
   input  wire logic [13:0] sampleCode,
   input  wire logic        serialClk,
   output logic             busy,
   output logic             powerDown,
   output logic             serialResultOut,
   output logic             serialResultOeN
);
   sac_pkg::sac_state_t          state_reg;
   logic [sac_pkg::CNT_W-1:0]    cnt_reg;
   logic                         pending_reg;
   logic                         busy_reg;
   logic                         convPrev_reg;
   logic [sac_pkg::DATA_W-1:0]   held_reg;
   logic [sac_pkg::FRAME_W-1:0]  resultWord_reg;
   logic                         resultGen_reg;
   logic                         convLevel;
   logic                         modeLevel;
   logic [sac_pkg::DATA_W-1:0]   codeLevel;
   logic                         doneSync;
   logic                         startFall;
   logic                         startRise;
   logic                         startAccept;
   logic                         convEnd;
   logic                         linkRstMeta_reg;
   logic                         linkRst_reg;
   logic                         genSeen_reg;
   logic [sac_pkg::BITCNT_W-1:0] bitCnt_reg;
   logic                         dataOut_reg;
   logic                         doneTgl_reg;
   logic                         newFrame;
   logic                         linkDrive;
   logic [sac_pkg::CNT_W-1:0]    convLen_reg;
   logic [sac_pkg::CNT_W-1:0]    wakeLen_reg;

   sac_sync2 #(.WIDTH(1)) uConvSync (
      .clk  (clk_sys),
      .din  (conversionStartN),
      .dout (convLevel)
   );
   sac_sync2 #(.WIDTH(1)) uModeSync (
      .clk  (clk_sys),
      .din  (unipolarMode),
      .dout (modeLevel)
   );
   sac_sync2 #(.WIDTH(sac_pkg::DATA_W)) uCodeSync (
      .clk  (clk_sys),
      .din  (sampleCode),
      .dout (codeLevel)
   );
   sac_sync2 #(.WIDTH(1)) uDoneSync (
      .clk  (clk_sys),
      .din  (doneTgl_reg),
      .dout (doneSync)
   );

   // Edge detection only: a held low level starts nothing
   assign startFall   = convPrev_reg & ~convLevel;
   assign startRise   = ~convPrev_reg & convLevel;
   assign startAccept = startFall && (state_reg == sac_pkg::ST_IDLE || state_reg == sac_pkg::ST_WAKE);
   assign convEnd     = (state_reg == sac_pkg::ST_CONVERT) && (cnt_reg == sac_pkg::CNT_RST);

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         convPrev_reg <= 1'b1;
      end else begin
         convPrev_reg <= convLevel;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_reg   <= sac_pkg::ST_IDLE;
         cnt_reg     <= sac_pkg::CNT_RST;
         pending_reg <= 1'b0;
      end else begin
         unique case (state_reg)
            sac_pkg::ST_IDLE: begin
               if (startFall) begin
                  state_reg <= sac_pkg::ST_CONVERT;
                  cnt_reg   <= sac_pkg::CONV_CYCLES - 9'h001;
               end
            end
            sac_pkg::ST_CONVERT: begin
               if (cnt_reg == sac_pkg::CNT_RST) begin
                  // Start still low at the end: sleep until it rises
                  state_reg <= convLevel ? sac_pkg::ST_IDLE : sac_pkg::ST_POWERDOWN;
               end else begin
                  cnt_reg <= cnt_reg - 9'h001;
               end
            end
            sac_pkg::ST_POWERDOWN: begin
               if (startRise) begin
                  state_reg <= sac_pkg::ST_WAKE;
                  cnt_reg   <= sac_pkg::WAKE_CYCLES - 9'h001;
               end
            end
            sac_pkg::ST_WAKE: begin
               if (cnt_reg == sac_pkg::CNT_RST) begin
                  // A start taken while waking converts once awake
                  state_reg   <= (pending_reg | startFall) ? sac_pkg::ST_CONVERT : sac_pkg::ST_IDLE;
                  cnt_reg     <= sac_pkg::CONV_CYCLES - 9'h001;
                  pending_reg <= 1'b0;
               end else begin
                  cnt_reg <= cnt_reg - 9'h001;
                  if (startFall) begin
                     pending_reg <= 1'b1;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         busy_reg <= 1'b0;
      end else begin
         busy_reg <= (busy_reg | startAccept) & ~convEnd;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         held_reg <= sac_pkg::CODE_RST;
      end else if (startAccept) begin
         held_reg <= codeLevel;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (srst) begin
         resultWord_reg <= sac_pkg::WORD_RST;
         resultGen_reg  <= 1'b0;
      end else if (convEnd) begin
         resultWord_reg <= {sac_pkg::LEAD_ZEROS,
                            modeLevel ? held_reg : (held_reg ^ sac_pkg::SIGN_FLIP)};
         resultGen_reg  <= ~resultGen_reg;
      end
   end

   assign busy      = busy_reg;
   assign powerDown = (state_reg == sac_pkg::ST_POWERDOWN);

   // Link side, clocked by the host's shift clock only
   always_ff @(negedge serialClk) begin
      linkRstMeta_reg <= srst;
      linkRst_reg     <= linkRstMeta_reg;
   end

   // Result word and its generation bit change at every conversion end, also while a frame is read
   assign newFrame = (genSeen_reg != resultGen_reg);

   always_ff @(negedge serialClk) begin
      if (linkRst_reg) begin
         genSeen_reg <= 1'b0;
         bitCnt_reg  <= sac_pkg::BITCNT_IDLE;
         dataOut_reg <= 1'b0;
         doneTgl_reg <= 1'b0;
      end else if (newFrame) begin
         genSeen_reg <= resultGen_reg;
         bitCnt_reg  <= sac_pkg::BITCNT_FIRST;
         dataOut_reg <= resultWord_reg[sac_pkg::FRAME_W-1];
      end else if (bitCnt_reg != sac_pkg::BITCNT_IDLE && bitCnt_reg != sac_pkg::BITCNT_LAST) begin
         bitCnt_reg  <= bitCnt_reg + 5'h01;
         dataOut_reg <= resultWord_reg[4'(sac_pkg::BITCNT_PRE - bitCnt_reg)];
         if (bitCnt_reg == sac_pkg::BITCNT_PRE) begin
            doneTgl_reg <= ~doneTgl_reg;
         end
      end
   end

   // Last bit stays until the system side has seen the frame end
   assign linkDrive = (bitCnt_reg != sac_pkg::BITCNT_IDLE) &&
                      !((bitCnt_reg == sac_pkg::BITCNT_LAST) && (doneTgl_reg == doneSync));
   assign serialResultOut = dataOut_reg;
   assign serialResultOeN = ~linkDrive;

   // Helper counters for checking
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         convLen_reg <= sac_pkg::CNT_RST;
         wakeLen_reg <= sac_pkg::CNT_RST;
      end else begin
         convLen_reg <= (state_reg == sac_pkg::ST_CONVERT) ? convLen_reg + 9'h001 : sac_pkg::CNT_RST;
         wakeLen_reg <= (state_reg == sac_pkg::ST_WAKE) ? wakeLen_reg + 9'h001 : sac_pkg::CNT_RST;
      end
   end

   sequence s_idle_start;
      startFall && state_reg == sac_pkg::ST_IDLE;
   endsequence
   sequence s_busy_held;
      busy_reg [*8];
   endsequence

   property p_busy_rise;
      @(posedge clk_sys) disable iff (srst) s_idle_start |=> s_busy_held;
   endproperty
   a_busy_rise: assert property (p_busy_rise) else $error("busy not raised by start edge");

   property p_edge_only;
      @(posedge clk_sys) disable iff (srst)
         (state_reg == sac_pkg::ST_IDLE && !startFall) |=> state_reg != sac_pkg::ST_CONVERT;
   endproperty
   a_edge_only: assert property (p_edge_only) else $error("conversion began without edge");

   property p_conv_len;
      @(posedge clk_sys) disable iff (srst)
         $fell(state_reg == sac_pkg::ST_CONVERT) |-> convLen_reg == sac_pkg::CONV_CYCLES && !busy_reg;
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

   property p_wake_len;
      @(posedge clk_sys) disable iff (srst)
         $fell(state_reg == sac_pkg::ST_WAKE) |-> wakeLen_reg == sac_pkg::WAKE_CYCLES;
   endproperty
   a_wake_len: assert property (p_wake_len) else $error("wake length wrong");

   property p_sleep;
      @(posedge clk_sys) disable iff (srst)
         (convEnd && !convLevel) |=> powerDown ##1 (powerDown || startRise || $past(startRise));
   endproperty
   a_sleep: assert property (p_sleep) else $error("no power down after conversion");

   property p_wake;
      @(posedge clk_sys) disable iff (srst)
         (powerDown && startRise) |=> state_reg == sac_pkg::ST_WAKE && !powerDown;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake on rising start");

   property p_coding;
      @(posedge clk_sys) disable iff (srst)
         convEnd |=> resultWord_reg == {2'h0, $past(modeLevel) ? $past(held_reg)
                                               : ($past(held_reg) ^ 14'h2000)};
   endproperty
   a_coding: assert property (p_coding) else $error("result coding wrong");

   property p_frame_start;
      @(negedge serialClk) disable iff (linkRst_reg)
         newFrame |=> bitCnt_reg == 5'h01 && !serialResultOut ##1 !serialResultOut;
   endproperty
   a_frame_start: assert property (p_frame_start) else $error("frame start wrong");

   // A fresh result replaces the word while the old last bit still stands
   property p_bit_order;
      @(negedge serialClk) disable iff (linkRst_reg)
         (bitCnt_reg != 5'h00 && !newFrame) |->
            dataOut_reg == resultWord_reg[4'(5'h10 - bitCnt_reg)];
   endproperty
   a_bit_order: assert property (p_bit_order) else $error("wrong bit presented");

   property p_lead_zero;
      @(negedge serialClk) disable iff (linkRst_reg)
         (bitCnt_reg == 5'h01 || bitCnt_reg == 5'h02) |-> !serialResultOut;
   endproperty
   a_lead_zero: assert property (p_lead_zero) else $error("leading zero missing");

   // Frame end still in flight to the system side: release follows shortly
   property p_release;
      @(posedge clk_sys) disable iff (srst)
         (bitCnt_reg == 5'h10 && doneTgl_reg != doneSync) |-> ##[1:3] serialResultOeN;
   endproperty
   a_release: assert property (p_release) else $error("output not released");
endmodule

// file: verif/sac_host_model.sv
// Host model that clocks result frames out of the serial port
`timescale 1ns/1ns
module sac_host_model (
   input  wire logic serialResultOut,
   input  wire logic serialResultOeN,
   output logic      serialClk
);
   logic lineLvl;
   logic lastBit;
   // Released line shows the inverse of the last driven bit
   assign lineLvl = serialResultOeN ? ~lastBit : serialResultOut;
   initial begin
      serialClk = 1'b0;
      lastBit = 1'b0;
   end
   always @(serialResultOut or serialResultOeN) begin
      if (!serialResultOeN) begin
         lastBit = serialResultOut;
      end
   end
   // Clock stands still outside frames; bits taken just after each falling edge
   task automatic clock_edges(input int n, output logic [15:0] word, output int relCnt);
      word = 16'h0000;
      relCnt = 0;
      #3;
      repeat (n) begin
         #30 serialClk = 1'b1;
         #32 serialClk = 1'b0;
         #5;
         word = {word[14:0], lineLvl};
         relCnt += serialResultOeN;
         #58;
      end
   endtask
endmodule

// file: verif/tb.sv
// Self-checking bench for the converter control and serial readout
`timescale 1ns/1ns
module tb;
   typedef struct {logic uni; logic [13:0] smp; logic [15:0] exp;} sac_row_t;
   logic        clk_sys, srst, conversionStartN, unipolarMode, serialClk;
   logic [13:0] sampleCode;
   logic        busy, powerDown, serialResultOut, serialResultOeN;
   logic [15:0] word;
   int          bad_count, compares, relCnt, i, busyRun, lastHi;
   sac_row_t    rows [6] = '{'{1'b1, 14'h0000, 16'h0000}, '{1'b1, 14'h3fff, 16'h3fff},
      '{1'b1, 14'h1234, 16'h1234}, '{1'b0, 14'h0000, 16'h2000},
      '{1'b0, 14'h3fff, 16'h1fff}, '{1'b0, 14'h2a5b, 16'h0a5b}};

   sac_readout sac_readout_i (.clk_sys(clk_sys), .srst(srst),
      .conversionStartN(conversionStartN), .unipolarMode(unipolarMode),
      .sampleCode(sampleCode), .serialClk(serialClk), .busy(busy), .powerDown(powerDown),
      .serialResultOut(serialResultOut), .serialResultOeN(serialResultOeN));
   sac_host_model sac_host_model_i (.serialResultOut(serialResultOut),
      .serialResultOeN(serialResultOeN), .serialClk(serialClk));

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // Length of the last busy pulse in cycles
   always @(negedge clk_sys) begin
      if (busy === 1'b1) begin
         busyRun <= busyRun + 1;
      end else if (busyRun != 0) begin
         lastHi <= busyRun;
         busyRun <= 0;
      end
   end

   task automatic fail(input string msg);
      bad_count++;
      $display("[FAIL] %0t %s", $time, msg);
   endtask
   task automatic check_bit(input logic got, input logic exp, input string msg);
      compares++;
      if (got !== exp) fail(msg);
   endtask
   task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
      compares++;
      if (got !== exp) fail(msg);
   endtask
   task automatic check_num(input int got, input int exp, input string msg);
      compares++;
      if (got != exp) fail(msg);
   endtask
   task automatic wait_busy(input logic v, input int lim);
      int n;
      n = 0;
      while (busy !== v && n < lim) begin
         @(negedge clk_sys);
         n++;
      end
      check_bit(busy, v, "busy level");
   endtask
   task automatic pulse_start(input int lowCyc);
      @(negedge clk_sys) conversionStartN = 1'b0;
      repeat (lowCyc) @(negedge clk_sys);
      conversionStartN = 1'b1;
   endtask
   task automatic report_and_stop;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      #400000;
      fail("watchdog");
      report_and_stop;
   end

   initial begin
      srst = 1'b1;
      conversionStartN = 1'b1;
      unipolarMode = 1'b0;
      sampleCode = 14'h0000;
      bad_count = 0;
      compares = 0;
      busyRun = 0;
      lastHi = 0;
      fork
         repeat (6) @(negedge clk_sys);
         sac_host_model_i.clock_edges(4, word, relCnt);
      join
      @(negedge clk_sys) srst = 1'b0;
      repeat (4) @(negedge clk_sys);
      check_bit(busy, 1'b0, "reset busy");
      check_bit(powerDown, 1'b0, "reset sleep");
      check_bit(serialResultOeN, 1'b1, "reset release");
      // Link side leaves reset only on its own clock edges
      sac_host_model_i.clock_edges(4, word, relCnt);
      check_num(relCnt, 4, "idle link");
      @(negedge clk_sys);
      $display("test reset done");
      for (i = 0; i < 6; i++) begin
         unipolarMode = rows[i].uni;
         sampleCode = rows[i].smp;
         repeat (4) @(negedge clk_sys);
         pulse_start(5);
         wait_busy(1'b0, 300);
         @(negedge clk_sys);
         check_num(lastHi, 250, "busy span");
         sac_host_model_i.clock_edges(16, word, relCnt);
         check_word(word, rows[i].exp, "frame");
         check_num(relCnt, 0, "driven in frame");
         repeat (10) @(negedge clk_sys);
         check_bit(serialResultOeN, 1'b1, "release");
      end
      $display("test rows done");
      pulse_start(5);
      repeat (100) @(negedge clk_sys);
      pulse_start(5);
      wait_busy(1'b0, 300);
      @(negedge clk_sys);
      check_num(lastHi, 250, "restart ignored");
      repeat (20) @(negedge clk_sys);
      check_bit(busy, 1'b0, "no second run");
      $display("test start during conversion done");
      unipolarMode = 1'b1;
      sampleCode = 14'h0abc;
      @(negedge clk_sys) conversionStartN = 1'b0;
      wait_busy(1'b1, 6);
      wait_busy(1'b0, 300);
      repeat (50) @(negedge clk_sys);
      check_bit(powerDown, 1'b1, "sleep");
      check_bit(busy, 1'b0, "held low idle");
      conversionStartN = 1'b1;
      repeat (20) @(negedge clk_sys);
      pulse_start(5);
      wait_busy(1'b1, 6);
      check_bit(powerDown, 1'b0, "woken");
      wait_busy(1'b0, 600);
      @(negedge clk_sys);
      check_bit(lastHi >= 470 && lastHi <= 486, 1'b1, "sleep span");
      sac_host_model_i.clock_edges(16, word, relCnt);
      check_word(word, 16'h0abc, "sleep frame");
      repeat (10) @(negedge clk_sys);
      sac_host_model_i.clock_edges(4, word, relCnt);
      check_num(relCnt, 4, "extra edges");
      $display("test auto sleep done");
      report_and_stop;
   end
endmodule
